// file: common/mpps_pkg.sv
// Functional notes
// - 06h latches signed target; sign sets direction
// - counter-relative drive reverses the target direction
// - absolute target measured from logical zero
// - same-direction target rewrite in relative modes; passed target stops
// - 07h manual decel point, used when selected
// - output count is target magnitude or distance
// - 09h loads logical counter; read via 30h
// - logical counter follows plus/minus output pulses
// - 0Ah loads encoder counter; read via 31h
// - encoder counter follows encoder input pulses
// - 0Bh loads upper soft limit threshold
// - 0Ch loads lower soft limit threshold
// - 0Dh loads signed offset, resets to zero
// - 0Eh logical ring max, all-ones means off
// - 0Fh encoder ring max, all-ones means off
// - 10h loads compare zero; read via 34h
// - 11h loads compare one; read via 35h
// - compare results drive compare outputs
package mpps_pkg;
  // command codes
  localparam logic [7:0] CMD_TGT   = 8'h06;
  localparam logic [7:0] CMD_DECPT = 8'h07;
  localparam logic [7:0] CMD_LPOS  = 8'h09;
  localparam logic [7:0] CMD_EPOS  = 8'h0a;
  localparam logic [7:0] CMD_SLP   = 8'h0b;
  localparam logic [7:0] CMD_SLM   = 8'h0c;
  localparam logic [7:0] CMD_OFS   = 8'h0d;
  localparam logic [7:0] CMD_LMAX  = 8'h0e;
  localparam logic [7:0] CMD_RX    = 8'h0f;
  localparam logic [7:0] CMD_CMP0  = 8'h10;
  localparam logic [7:0] CMD_CMP1  = 8'h11;
  localparam logic [7:0] RD_LPOS   = 8'h30;
  localparam logic [7:0] RD_EPOS   = 8'h31;
  localparam logic [7:0] RD_CMP0   = 8'h34;
  localparam logic [7:0] RD_CMP1   = 8'h35;
  // register byte offsets
  localparam logic [7:0] ADR_CMD   = 8'h00;
  localparam logic [7:0] ADR_LOW   = 8'h04;
  localparam logic [7:0] ADR_HIGH  = 8'h08;
  localparam logic [7:0] ADR_LIMIT = 8'h0c;
  localparam logic [7:0] ADR_ACCEL = 8'h10;
  localparam logic [7:0] ADR_RDATA = 8'h14;
  localparam logic [7:0] ADR_DRIVE = 8'h18;
  localparam logic [7:0] ADR_STAT  = 8'h1c;
  localparam logic [7:0] ADR_OFS   = 8'h20;
  // field positions
  localparam int LIM_PLUS_EN  = 0;
  localparam int LIM_MINUS_EN = 1;
  localparam int LIM_SRC_ENC  = 2;
  localparam int LIM_DEC_STOP = 3;
  localparam int MAN_DEC_BIT  = 0;
  localparam int DRV_START    = 2;
  localparam int DRV_STOP     = 3;
  localparam logic [1:0] MODE_REL  = 2'h0;
  localparam logic [1:0] MODE_CREL = 2'h1;
  localparam logic [1:0] MODE_ABS  = 2'h2;
  // reset values
  localparam logic [31:0] RING_OFF = 32'hffffffff;
  localparam logic [15:0] AO_RST   = 16'h0000;
  // timing
  localparam int CLK_MHZ        = 20;
  localparam int CMD_ACCESS_NS  = 125;
  localparam int CMD_BUSY_RAW   = (CMD_ACCESS_NS * CLK_MHZ) / 1000;
  localparam int CMD_BUSY_CYC   = (CMD_BUSY_RAW < 1) ? 1 : CMD_BUSY_RAW;
  localparam int STEP_DIV_DEF   = 20;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } mpps_state_t;
endpackage : mpps_pkg

// file: core/mpps_core.sv
// Implementation choices: the address map and the Wishbone register port.
`timescale 1ns/100ps
module mpps_core #(
  parameter int STEP_DIV = mpps_pkg::STEP_DIV_DEF
) (
  // clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RST,
  // wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  // encoder pulses
  input  wire logic        ENC_UP,
  input  wire logic        ENC_DOWN,
  // drive outputs
  output logic             PULSE_PLUS,
  output logic             PULSE_MINUS,
  output logic             DRIVE_BUSY,
  output logic             DECEL_ACTIVE,
  output logic             CMP_ZERO_OUT,
  output logic             CMP_ONE_OUT
);
  import mpps_pkg::*;

  function automatic logic [31:0] ring_step(input logic [31:0] v,
                                            input logic [31:0] mx,
                                            input logic        up);
    if (mx == RING_OFF) begin
      ring_step = up ? v + 32'h1 : v - 32'h1;
    end else if (up) begin
      ring_step = (v == mx) ? 32'h0 : v + 32'h1;
    end else begin
      ring_step = (v == 32'h0) ? mx : v - 32'h1;
    end
  endfunction : ring_step

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  sel);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = sel[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
  endfunction : merge

  function automatic logic [31:0] mag(input logic [31:0] v);
    mag = v[31] ? (32'h0 - v) : v;
  endfunction : mag

  // bus and parameter state
  logic [31:0] wb_dat_ff, nxt_wb_dat;
  logic        wb_ack_ff, nxt_wb_ack;
  logic [15:0] low_data_ff, nxt_low_data;
  logic [15:0] high_data_ff, nxt_high_data;
  logic [3:0]  limit_ctl_ff, nxt_limit_ctl;
  logic        accel_mode_ff, nxt_accel_mode;
  logic [1:0]  drive_mode_ff, nxt_drive_mode;
  logic [7:0]  rd_sel_ff, nxt_rd_sel;
  logic [1:0]  cmd_busy_ff, nxt_cmd_busy;
  logic [31:0] target_pulse_count_ff, nxt_target_pulse_count;
  logic [31:0] manual_decel_point_ff, nxt_manual_decel_point;
  logic [31:0] logical_position_count_ff, nxt_logical_position_count;
  logic [31:0] encoder_position_count_ff, nxt_encoder_position_count;
  logic [31:0] upper_soft_limit_reg_ff, nxt_upper_soft_limit_reg;
  logic [31:0] lower_soft_limit_reg_ff, nxt_lower_soft_limit_reg;
  logic [15:0] accel_count_offset_ff, nxt_accel_count_offset;
  logic [31:0] logical_ring_max_ff, nxt_logical_ring_max;
  logic [31:0] encoder_ring_max_ff, nxt_encoder_ring_max;
  logic [31:0] compare_value_zero_ff, nxt_compare_value_zero;
  logic [31:0] compare_value_one_ff, nxt_compare_value_one;
  // drive state
  mpps_state_t state_ff, nxt_state;
  logic [31:0] total_ff, nxt_total;
  logic [31:0] done_ff, nxt_done;
  logic        dir_minus_ff, nxt_dir_minus;
  logic [15:0] div_ff, nxt_div;
  logic        plus_ff, nxt_plus;
  logic        minus_ff, nxt_minus;
  logic        busy_ff, nxt_busy;
  logic        decel_ff, nxt_decel;
  logic        cmp0_ff, nxt_cmp0;
  logic        cmp1_ff, nxt_cmp1;
  logic        lim_stop_ff, nxt_lim_stop;

  logic        req;
  logic        wr;
  logic        cmd_wr;
  logic [7:0]  cmd;
  logic [31:0] data32;
  logic [31:0] rd_value;
  logic [31:0] lim_src;
  logic        hit_upper;
  logic        hit_lower;
  logic [31:0] diff;

  always_comb begin
    req    = WB_CYC_I && WB_STB_I && !wb_ack_ff;
    wr     = req && WB_WE_I;
    cmd_wr = wr && (WB_ADR_I == ADR_CMD) && WB_SEL_I[0];
    cmd    = WB_DAT_I[7:0];
    data32 = {high_data_ff, low_data_ff};
    case (rd_sel_ff)
      RD_LPOS: rd_value = logical_position_count_ff;
      RD_EPOS: rd_value = encoder_position_count_ff;
      RD_CMP0: rd_value = compare_value_zero_ff;
      RD_CMP1: rd_value = compare_value_one_ff;
      default: rd_value = 32'h0;
    endcase
    lim_src   = limit_ctl_ff[LIM_SRC_ENC] ? encoder_position_count_ff
                                          : logical_position_count_ff;
    hit_upper = limit_ctl_ff[LIM_PLUS_EN]
                && ($signed(lim_src) >= $signed(upper_soft_limit_reg_ff));
    hit_lower = limit_ctl_ff[LIM_MINUS_EN]
                && ($signed(lim_src) <= $signed(lower_soft_limit_reg_ff));
    diff      = target_pulse_count_ff - logical_position_count_ff;
  end

  always_comb begin
    nxt_wb_ack                 = req;
    nxt_wb_dat                 = wb_dat_ff;
    nxt_low_data               = low_data_ff;
    nxt_high_data              = high_data_ff;
    nxt_limit_ctl              = limit_ctl_ff;
    nxt_accel_mode             = accel_mode_ff;
    nxt_drive_mode             = drive_mode_ff;
    nxt_rd_sel                 = rd_sel_ff;
    nxt_cmd_busy               = (cmd_busy_ff != 2'h0) ? cmd_busy_ff - 2'h1 : 2'h0;
    nxt_target_pulse_count     = target_pulse_count_ff;
    nxt_manual_decel_point     = manual_decel_point_ff;
    nxt_logical_position_count = logical_position_count_ff;
    nxt_encoder_position_count = encoder_position_count_ff;
    nxt_upper_soft_limit_reg   = upper_soft_limit_reg_ff;
    nxt_lower_soft_limit_reg   = lower_soft_limit_reg_ff;
    nxt_accel_count_offset     = accel_count_offset_ff;
    nxt_logical_ring_max       = logical_ring_max_ff;
    nxt_encoder_ring_max       = encoder_ring_max_ff;
    nxt_compare_value_zero     = compare_value_zero_ff;
    nxt_compare_value_one      = compare_value_one_ff;
    nxt_state                  = state_ff;
    nxt_total                  = total_ff;
    nxt_done                   = done_ff;
    nxt_dir_minus              = dir_minus_ff;
    nxt_div                    = div_ff;
    nxt_plus                   = 1'b0;
    nxt_minus                  = 1'b0;
    nxt_lim_stop               = lim_stop_ff;

    // counters count first so that a command load in the same cycle wins
    if (ENC_UP != ENC_DOWN) begin
      nxt_encoder_position_count = ring_step(encoder_position_count_ff,
                                             encoder_ring_max_ff, ENC_UP);
    end
    if (plus_ff || minus_ff) begin
      nxt_logical_position_count = ring_step(logical_position_count_ff,
                                             logical_ring_max_ff, plus_ff);
    end

    // drive sequencer
    case (state_ff)
      ST_IDLE: begin
        if (wr && (WB_ADR_I == ADR_DRIVE) && WB_SEL_I[0] && WB_DAT_I[DRV_START]) begin
          nxt_done     = 32'h0;
          nxt_div      = 16'h0;
          nxt_lim_stop = 1'b0;
          if (WB_DAT_I[1:0] == MODE_ABS) begin
            nxt_total     = mag(diff);
            nxt_dir_minus = diff[31];
          end else begin
            nxt_total     = mag(target_pulse_count_ff);
            nxt_dir_minus = target_pulse_count_ff[31] ^
                            (WB_DAT_I[1:0] == MODE_CREL);
          end
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (div_ff == 16'(STEP_DIV - 1)) begin
          nxt_div = 16'h0;
        end else begin
          nxt_div = div_ff + 16'h1;
        end
        if (wr && (WB_ADR_I == ADR_DRIVE) && WB_SEL_I[0] && WB_DAT_I[DRV_STOP]) begin
          nxt_state = ST_IDLE;
        end else if ((!dir_minus_ff && hit_upper) || (dir_minus_ff && hit_lower)) begin
          nxt_lim_stop = 1'b1;
          nxt_state    = ST_IDLE;
        end else if (done_ff >= total_ff) begin
          // a rewritten target already passed ends the drive here at once
          nxt_state = ST_IDLE;
        end else if (div_ff == 16'(STEP_DIV - 1)) begin
          nxt_plus  = !dir_minus_ff;
          nxt_minus = dir_minus_ff;
          nxt_done  = done_ff + 32'h1;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase

    // register writes
    if (wr) begin
      case (WB_ADR_I)
        ADR_LOW: begin
          if (WB_SEL_I[0]) nxt_low_data[7:0] = WB_DAT_I[7:0];
          if (WB_SEL_I[1]) nxt_low_data[15:8] = WB_DAT_I[15:8];
        end
        ADR_HIGH: begin
          if (WB_SEL_I[0]) nxt_high_data[7:0] = WB_DAT_I[7:0];
          if (WB_SEL_I[1]) nxt_high_data[15:8] = WB_DAT_I[15:8];
        end
        ADR_LIMIT: if (WB_SEL_I[0]) nxt_limit_ctl = WB_DAT_I[3:0];
        ADR_ACCEL: if (WB_SEL_I[0]) nxt_accel_mode = WB_DAT_I[MAN_DEC_BIT];
        ADR_DRIVE: begin
          if (WB_SEL_I[0] && state_ff == ST_IDLE) nxt_drive_mode = WB_DAT_I[1:0];
        end
        default: nxt_rd_sel = rd_sel_ff;
      endcase
    end
    if (cmd_wr) begin
      nxt_cmd_busy = 2'(CMD_BUSY_CYC);
      case (cmd)
        CMD_TGT: begin
          nxt_target_pulse_count = data32;
          // relative rewrites retarget the running count; absolute keeps it
          if (state_ff == ST_RUN && drive_mode_ff != MODE_ABS) begin
            nxt_total = mag(data32);
          end
        end
        CMD_DECPT: nxt_manual_decel_point = data32;
        CMD_LPOS:  nxt_logical_position_count = data32;
        CMD_EPOS:  nxt_encoder_position_count = data32;
        CMD_SLP:   nxt_upper_soft_limit_reg = data32;
        CMD_SLM:   nxt_lower_soft_limit_reg = data32;
        CMD_OFS:   nxt_accel_count_offset = low_data_ff;
        CMD_LMAX:  nxt_logical_ring_max = data32;
        CMD_RX:    nxt_encoder_ring_max = data32;
        CMD_CMP0:  nxt_compare_value_zero = data32;
        CMD_CMP1:  nxt_compare_value_one = data32;
        RD_LPOS, RD_EPOS, RD_CMP0, RD_CMP1: nxt_rd_sel = cmd;
        default: nxt_rd_sel = rd_sel_ff;
      endcase
    end

    // read path
    if (req && !WB_WE_I) begin
      case (WB_ADR_I)
        ADR_LOW:   nxt_wb_dat = {16'h0, low_data_ff};
        ADR_HIGH:  nxt_wb_dat = {16'h0, high_data_ff};
        ADR_LIMIT: nxt_wb_dat = {28'h0, limit_ctl_ff};
        ADR_ACCEL: nxt_wb_dat = {31'h0, accel_mode_ff};
        ADR_RDATA: nxt_wb_dat = rd_value;
        ADR_DRIVE: nxt_wb_dat = {30'h0, drive_mode_ff};
        ADR_STAT:  nxt_wb_dat = {24'h0, hit_lower, hit_upper, cmd_busy_ff != 2'h0,
                                 lim_stop_ff, cmp1_ff, cmp0_ff, decel_ff, busy_ff};
        ADR_OFS:   nxt_wb_dat = {{16{accel_count_offset_ff[15]}}, accel_count_offset_ff};
        default:   nxt_wb_dat = 32'h0;
      endcase
    end

    nxt_busy  = (nxt_state == ST_RUN);
    nxt_decel = (state_ff == ST_RUN) && accel_mode_ff
                && (done_ff >= manual_decel_point_ff);
    nxt_cmp0  = ($signed(logical_position_count_ff)
                 >= $signed(compare_value_zero_ff));
    nxt_cmp1  = ($signed(logical_position_count_ff)
                 >= $signed(compare_value_one_ff));
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      wb_dat_ff                 <= 32'h0;
      wb_ack_ff                 <= 1'b0;
      low_data_ff               <= 16'h0;
      high_data_ff              <= 16'h0;
      limit_ctl_ff              <= 4'h0;
      accel_mode_ff             <= 1'b0;
      drive_mode_ff             <= MODE_REL;
      rd_sel_ff                 <= RD_LPOS;
      cmd_busy_ff               <= 2'h0;
      target_pulse_count_ff     <= 32'h0;
      manual_decel_point_ff     <= 32'h0;
      logical_position_count_ff <= 32'h0;
      encoder_position_count_ff <= 32'h0;
      upper_soft_limit_reg_ff   <= 32'h0;
      lower_soft_limit_reg_ff   <= 32'h0;
      accel_count_offset_ff     <= AO_RST;
      logical_ring_max_ff       <= RING_OFF;
      encoder_ring_max_ff       <= RING_OFF;
      compare_value_zero_ff     <= 32'h0;
      compare_value_one_ff      <= 32'h0;
      state_ff                  <= ST_IDLE;
      total_ff                  <= 32'h0;
      done_ff                   <= 32'h0;
      dir_minus_ff              <= 1'b0;
      div_ff                    <= 16'h0;
      plus_ff                   <= 1'b0;
      minus_ff                  <= 1'b0;
      busy_ff                   <= 1'b0;
      decel_ff                  <= 1'b0;
      cmp0_ff                   <= 1'b0;
      cmp1_ff                   <= 1'b0;
      lim_stop_ff               <= 1'b0;
    end else begin
      wb_dat_ff                 <= nxt_wb_dat;
      wb_ack_ff                 <= nxt_wb_ack;
      low_data_ff               <= nxt_low_data;
      high_data_ff              <= nxt_high_data;
      limit_ctl_ff              <= nxt_limit_ctl;
      accel_mode_ff             <= nxt_accel_mode;
      drive_mode_ff             <= nxt_drive_mode;
      rd_sel_ff                 <= nxt_rd_sel;
      cmd_busy_ff               <= nxt_cmd_busy;
      target_pulse_count_ff     <= nxt_target_pulse_count;
      manual_decel_point_ff     <= nxt_manual_decel_point;
      logical_position_count_ff <= nxt_logical_position_count;
      encoder_position_count_ff <= nxt_encoder_position_count;
      upper_soft_limit_reg_ff   <= nxt_upper_soft_limit_reg;
      lower_soft_limit_reg_ff   <= nxt_lower_soft_limit_reg;
      accel_count_offset_ff     <= nxt_accel_count_offset;
      logical_ring_max_ff       <= nxt_logical_ring_max;
      encoder_ring_max_ff       <= nxt_encoder_ring_max;
      compare_value_zero_ff     <= nxt_compare_value_zero;
      compare_value_one_ff      <= nxt_compare_value_one;
      state_ff                  <= nxt_state;
      total_ff                  <= nxt_total;
      done_ff                   <= nxt_done;
      dir_minus_ff              <= nxt_dir_minus;
      div_ff                    <= nxt_div;
      plus_ff                   <= nxt_plus;
      minus_ff                  <= nxt_minus;
      busy_ff                   <= nxt_busy;
      decel_ff                  <= nxt_decel;
      cmp0_ff                   <= nxt_cmp0;
      cmp1_ff                   <= nxt_cmp1;
      lim_stop_ff               <= nxt_lim_stop;
    end
  end

  assign WB_DAT_O     = wb_dat_ff;
  assign WB_ACK_O     = wb_ack_ff;
  assign PULSE_PLUS   = plus_ff;
  assign PULSE_MINUS  = minus_ff;
  assign DRIVE_BUSY   = busy_ff;
  assign DECEL_ACTIVE = decel_ff;
  assign CMP_ZERO_OUT = cmp0_ff;
  assign CMP_ONE_OUT  = cmp1_ff;
endmodule : mpps_core

// file: verif/mpps_core_properties.sv
`timescale 1ns/100ps
module mpps_core_chk (
  // clock and reset
  input wire logic        REF_CLK,
  input wire logic        RST,
  // bus
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [7:0]  WB_ADR_I,
  input wire logic [3:0]  WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        WB_ACK_O,
  // encoder and drive
  input wire logic        ENC_UP,
  input wire logic        ENC_DOWN,
  input wire logic        PULSE_PLUS,
  input wire logic        PULSE_MINUS,
  input wire logic        DRIVE_BUSY,
  input wire logic        DECEL_ACTIVE,
  input wire logic        CMP_ZERO_OUT,
  input wire logic        CMP_ONE_OUT
);
  import mpps_pkg::*;
  wire step = PULSE_PLUS || PULSE_MINUS;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  sequence s_take;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  sequence s_start;
    s_take ##0 WB_WE_I && WB_ADR_I == ADR_DRIVE && WB_SEL_I[0] && WB_DAT_I[DRV_START];
  endsequence
  chk_ack_follows: assert property (s_take |=> WB_ACK_O)
    else $error("no ack after request");
  chk_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  chk_hole_zero: assert property (s_take ##0 !WB_WE_I && WB_ADR_I > ADR_OFS |=> WB_DAT_O == 32'h0)
    else $error("unmapped read not zero");
  chk_one_direction: assert property (!(PULSE_PLUS && PULSE_MINUS))
    else $error("steps both ways at once");
  chk_step_in_drive: assert property (step |-> $past(DRIVE_BUSY))
    else $error("step outside drive");
  chk_step_spacing: assert property (step |=> !step)
    else $error("steps back to back");
  chk_decel_in_drive: assert property (DECEL_ACTIVE |-> $past(DRIVE_BUSY))
    else $error("decel outside drive");
  chk_start_no_step: assert property (s_start ##0 !DRIVE_BUSY |=> !step)
    else $error("step on start edge");
  // reset itself is the cause here, so it cannot disable the check
  chk_reset_quiet: assert property (disable iff (1'b0) RST |=> !WB_ACK_O && !DRIVE_BUSY && !step && !CMP_ZERO_OUT && !CMP_ONE_OUT)
    else $error("outputs active after reset");
endmodule : mpps_core_chk

bind mpps_core mpps_core_chk chk_inst (.REF_CLK(REF_CLK), .RST(RST),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
  .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
  .ENC_UP(ENC_UP), .ENC_DOWN(ENC_DOWN), .PULSE_PLUS(PULSE_PLUS),
  .PULSE_MINUS(PULSE_MINUS), .DRIVE_BUSY(DRIVE_BUSY), .DECEL_ACTIVE(DECEL_ACTIVE),
  .CMP_ZERO_OUT(CMP_ZERO_OUT), .CMP_ONE_OUT(CMP_ONE_OUT));

// file: verif/mpps_hm.sv
`timescale 1ns/100ps
module mpps_hm (
  // bus clock
  input  wire logic        clk,
  // bus answer
  input  wire logic        ack,
  input  wire logic [31:0] rdat,
  // bus request
  output logic             cyc,
  output logic             stb,
  output logic             we,
  output logic [7:0]       adr,
  output logic [3:0]       sel,
  output logic [31:0]      wdat
);
  import mpps_pkg::*;
  initial {cyc, stb, we, adr, sel, wdat} = '0;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk);
    {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, 4'hf, d};
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    {cyc, stb, we} <= 3'b000;
    // released data lines must not keep the last word
    wdat <= ~d;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0, q);
  endtask : rd
  task automatic op(input logic [7:0] c);
    logic [31:0] q;
    xfer(1'b1, ADR_CMD, {24'h0, c}, q);
    repeat (CMD_BUSY_CYC) @(posedge clk);
  endtask : op
  task automatic put(input logic [7:0] c, input logic [31:0] v);
    wr(ADR_LOW, {16'h0, v[15:0]});
    wr(ADR_HIGH, {16'h0, v[31:16]});
    op(c);
  endtask : put
endmodule : mpps_hm

// file: verif/tb_motion_position_parameter_set.sv
`timescale 1ns/100ps
module tb_motion_position_parameter_set;
  import mpps_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        enc_up = 1'b0;
  logic        enc_dn = 1'b0;
  logic        cyc, stb, we, ack, pplus, pminus, busy, decel, cmp0, cmp1;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, q;
  int          dn = 0;
  int          bad_count = 0;
  int          tests_run = 0;
  int          pp = 0;
  int          pm = 0;
  int          p0, m0;
  logic [7:0]  wc [4] = '{CMD_LPOS, CMD_EPOS, CMD_CMP0, CMD_CMP1};
  logic [7:0]  rc [4] = '{RD_LPOS, RD_EPOS, RD_CMP0, RD_CMP1};
  logic [1:0]  md [3] = '{MODE_REL, MODE_CREL, MODE_ABS};
  logic [31:0] tgt [3] = '{32'h3, 32'h2, 32'hffff_fffe};
  int          ep [3] = '{3, 0, 0};
  int          em [3] = '{0, 2, 3};
  logic [31:0] el [3] = '{32'h3, 32'h1, 32'hffff_fffe};

  always #25 clk = ~clk;
  always @(posedge clk) begin
    if (pplus) pp <= pp + 1;
    if (pminus) pm <= pm + 1;
    if (decel) dn <= dn + 1;
  end

  mpps_core #(.STEP_DIV(2)) mpps_core_inst (.REF_CLK(clk), .RST(rst), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
    .WB_DAT_O(rdat), .WB_ACK_O(ack), .ENC_UP(enc_up), .ENC_DOWN(enc_dn),
    .PULSE_PLUS(pplus), .PULSE_MINUS(pminus), .DRIVE_BUSY(busy), .DECEL_ACTIVE(decel),
    .CMP_ZERO_OUT(cmp0), .CMP_ONE_OUT(cmp1));
  mpps_hm mpps_hm_inst (.clk(clk), .ack(ack), .rdat(rdat), .cyc(cyc), .stb(stb),
    .we(we), .adr(adr), .sel(sel), .wdat(wdat));

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] c, output logic [31:0] v);
    mpps_hm_inst.op(c);
    mpps_hm_inst.rd(ADR_RDATA, v);
  endtask : rdc
  task automatic drv(input logic [1:0] m, input logic [31:0] t);
    mpps_hm_inst.put(CMD_TGT, t);
    mpps_hm_inst.wr(ADR_DRIVE, {28'h0, 2'b01, m});
  endtask : drv
  task automatic idle();
    for (int n = 0; n < 500 && busy !== 1'b0; n++) @(posedge clk);
    chk("drive end", {31'h0, busy}, 32'h0);
  endtask : idle
  task automatic enc(input logic up, input int n);
    @(posedge clk) {enc_up, enc_dn} <= up ? 2'b10 : 2'b01;
    repeat (n) @(posedge clk);
    {enc_up, enc_dn} <= 2'b00;
  endtask : enc
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    mpps_hm_inst.rd(ADR_RDATA, q);
    chk("pos reset", q, 32'h0);
    mpps_hm_inst.rd(ADR_OFS, q);
    chk("offset reset", q, {16'h0, AO_RST});
    mpps_hm_inst.rd(8'h40, q);
    chk("hole", q, 32'h0);
    for (int i = 0; i < 4; i++) begin
      mpps_hm_inst.put(wc[i], 32'h8765_4321 ^ i);
      rdc(rc[i], q);
      chk("readback", q, 32'h8765_4321 ^ i);
    end
    // stale high data must not leak into the 16-bit offset
    mpps_hm_inst.wr(ADR_HIGH, 32'h0000_5555);
    mpps_hm_inst.wr(ADR_LOW, 32'h0000_fffe);
    mpps_hm_inst.op(CMD_OFS);
    mpps_hm_inst.rd(ADR_OFS, q);
    chk("offset", q, 32'hffff_fffe);
    mpps_hm_inst.put(CMD_EPOS, 32'd10);
    mpps_hm_inst.put(CMD_RX, 32'd13);
    enc(1'b1, 3);
    enc(1'b0, 1);
    rdc(RD_EPOS, q);
    chk("encoder", q, 32'd12);
    enc(1'b1, 2);
    rdc(RD_EPOS, q);
    chk("encoder ring", q, 32'h0);
    mpps_hm_inst.put(CMD_LPOS, 32'h0);
    for (int i = 0; i < 3; i++) begin
      p0 = pp;
      m0 = pm;
      drv(md[i], tgt[i]);
      idle();
      chk("plus steps", pp - p0, ep[i]);
      chk("minus steps", pm - m0, em[i]);
      rdc(RD_LPOS, q);
      chk("pos", q, el[i]);
    end
    mpps_hm_inst.put(CMD_CMP0, 32'hffff_fffe);
    mpps_hm_inst.put(CMD_CMP1, 32'hffff_ffff);
    chk("compare", {30'h0, cmp0, cmp1}, 32'h2);
    mpps_hm_inst.put(CMD_DECPT, 32'h1);
    for (int m = 0; m < 2; m++) begin
      mpps_hm_inst.wr(ADR_ACCEL, m);
      p0 = dn;
      drv(MODE_REL, 32'h4);
      idle();
      chk("decel", {31'h0, dn > p0}, m);
    end
    for (int d = 0; d < 2; d++) begin
      mpps_hm_inst.put(CMD_LPOS, 32'h0);
      mpps_hm_inst.put(d ? CMD_SLM : CMD_SLP, d ? 32'hffff_fffe : 32'h2);
      mpps_hm_inst.wr(ADR_LIMIT, 32'h1 << d);
      drv(MODE_REL, d ? 32'hffff_fffa : 32'h6);
      idle();
      mpps_hm_inst.rd(ADR_STAT, q);
      chk("limit stop", {31'h0, q[4]}, 32'h1);
    end
    mpps_hm_inst.wr(ADR_LIMIT, 32'h0);
    // shrink the target below what is already done: drive must end
    p0 = pp;
    drv(MODE_REL, 32'd40);
    while (pp - p0 < 3) @(posedge clk);
    mpps_hm_inst.put(CMD_TGT, 32'h1);
    chk("rewrite stop", {31'h0, busy}, 32'h0);
    chk("rewrite early", {31'h0, pp - p0 < 20}, 32'h1);
    mpps_hm_inst.put(CMD_LMAX, 32'd5);
    mpps_hm_inst.put(CMD_LPOS, 32'd4);
    drv(MODE_REL, 32'h2);
    idle();
    rdc(RD_LPOS, q);
    chk("logical ring", q, 32'h0);
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    wrap_up();
  end
endmodule : tb_motion_position_parameter_set
